//--- logic/pin_function_pkg.sv
// Purpose: shared constants and types for the pin function block
// Assumes: 100 MHz system clock, 64-pin package
// Notes: carrier timing derived from clock rate
// Contract
// (RQ1) segment counts 0..4 keep 19 segment pins, all shared pins stay I/O
// (RQ2) counts 5..18 move shared pins to LCD from segment 37 downward
// (RQ3) port select 01 makes I/O four and five the two-wire clock and data
// (RQ4) port select 10 makes I/O four and five the three-wire pins
// (RQ5) three-wire data pin switches direction between device and EEPROM
// (RQ6) three-wire chip select comes from firmware on a spare I/O pin
// (RQ7) optical transmit drives only while transmit disable is zero
// (RQ8) separate bits invert transmit output and receive input polarity
// (RQ9) carrier enable with system power gates transmit by a 38 kHz carrier
// (RQ10) no carrier modulation in battery brownout mode
// (RQ11) two-bit duty select picks 50, 25, 12.5 or 6.25 percent
// (RQ12) duty percentage is the low fraction of each carrier period
// (RQ13) watchdog enabled only while sense input stays below 2.9 V
// (RQ14) device makes its own power-on reset, no external circuit needed
// (RQ15) flash lock is bit 6 of register b2; locked reprogram uses emulator pin
// (RQ16) locked reprogramming needs a watchdog reset between erase and program
// (RQ17) firmware writes segment counts only from 0 to 18
// (RQ18) duty codes 00,01,10,11 give 50,25,12.5,6.25 percent from system clock
// (RQ19) routing changes take effect one clock after a write, glitch free
`default_nettype none
package pin_function_pkg;
    localparam int          CLOCK_HZ        = 100_000_000;
    localparam int          CARRIER_HZ      = 38_000;
    localparam int          CARRIER_CYCLES  = CLOCK_HZ / CARRIER_HZ;
    localparam int          CARRIER_W       = $clog2(CARRIER_CYCLES);
    localparam int          SEG_COUNT_W     = 5;
    localparam int          SHARED_PINS     = 12;
    localparam int          DEDICATED_SEGS  = 19;
    localparam int          FIRST_MOVE      = 5;
    localparam int          KNEE_LOW        = 8;
    localparam int          KNEE_HIGH       = 10;
    localparam int          MAX_SEG_COUNT   = 18;
    localparam int          POR_CYCLES      = 16;
    localparam int          POR_W           = 5;
    localparam int          LOCK_SFR_ADDR   = 8'hb2;
    localparam int          LOCK_BIT        = 6;
    typedef enum logic [1:0] {
        port_gpio       = 2'h0,
        port_two_wire   = 2'h1,
        port_three_wire = 2'h2,
        port_reserved   = 2'h3
    } eeprom_port_t;
    typedef enum logic [1:0] {
        duty_half      = 2'h0,
        duty_quarter   = 2'h1,
        duty_eighth    = 2'h2,
        duty_sixteenth = 2'h3
    } duty_t;
endpackage
`default_nettype wire

//--- logic/carrier_if.sv
// Purpose: carrier link between top and generator
// Assumes: one clock domain
// Notes: run starts the carrier, low is the active low phase
`default_nettype none
interface carrier_if;
    import pin_function_pkg::*;
    logic  run;
    duty_t duty;
    logic  low;
    modport ctrl (output run, output duty, input low);
    modport gen  (input run, input duty, output low);
endinterface
`default_nettype wire

//--- logic/carrier_gen.sv
// Purpose: 38 kHz carrier with selectable low fraction
// Assumes: system clock at CLOCK_HZ
// Notes: phase restarts whenever run drops
`default_nettype none
module carrier_gen
    import pin_function_pkg::*;
(
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic enable,
    carrier_if.gen    cif
);
    logic [CARRIER_W-1:0] count_q, count_d;
    logic                 low_q, low_d;
    logic [CARRIER_W-1:0] low_len;

    always_comb begin
        unique case (cif.duty) // [RQ11] [RQ18]
            duty_half:      low_len = CARRIER_W'(CARRIER_CYCLES / 2);
            duty_quarter:   low_len = CARRIER_W'(CARRIER_CYCLES / 4);
            duty_eighth:    low_len = CARRIER_W'(CARRIER_CYCLES / 8);
            duty_sixteenth: low_len = CARRIER_W'(CARRIER_CYCLES / 16);
        endcase
        count_d = count_q;
        low_d   = low_q;
        if (!cif.run) begin
            count_d = '0;
            low_d   = 1'b0;
        end else begin
            count_d = (count_q == CARRIER_W'(CARRIER_CYCLES - 1))
                      ? '0 : count_q + 1'b1; // [RQ9]
            low_d   = (count_d < low_len); // [RQ12]
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            count_q <= '0;
            low_q   <= 1'b0;
        end else if (enable) begin
            count_q <= count_d;
            low_q   <= low_d;
        end
    end

    assign cif.low = low_q;
endmodule // carrier_gen
`default_nettype wire

//--- logic/pin_function_and_optical_tx.sv
// Purpose: shared pin split, EEPROM port routing, optical port control
// Assumes: configuration bits are plain inputs synchronous to clock
// Notes: all outputs registered; one cycle of latency on every path but the carrier, which adds a second
`default_nettype none
module pin_function_and_optical_tx
    import pin_function_pkg::*;
(
    input  wire logic                     clock,
    input  wire logic                     reset_n,
    input  wire logic                     enable,
    input  wire logic [SEG_COUNT_W-1:0]   segment_pin_count,
    input  wire pin_function_pkg::eeprom_port_t eeprom_port_select,
    input  wire logic                     optical_transmit_disable,
    input  wire logic                     optical_transmit_invert,
    input  wire logic                     optical_receive_invert,
    input  wire logic                     optical_carrier_enable,
    input  wire pin_function_pkg::duty_t  carrier_duty_select,
    input  wire logic                     system_power_ok,
    input  wire logic                     brownout_mode,
    input  wire logic                     uart_tx_data,
    output logic                          uart_rx_data,
    input  wire logic                     optical_receive_pin,
    output logic                          optical_transmit_pin,
    output logic                          optical_transmit_oe_n,
    input  wire logic                     eeprom_clock_out,
    input  wire logic                     eeprom_data_out,
    input  wire logic                     eeprom_data_drive,
    output logic                          eeprom_data_in,
    input  wire logic [1:0]               gpio_out,
    input  wire logic [1:0]               gpio_oe_n,
    output logic [1:0]                    gpio_in,
    input  wire logic                     general_io_four_in,
    input  wire logic                     general_io_five_in,
    output logic                          general_io_four_out,
    output logic                          general_io_four_oe_n,
    output logic                          general_io_five_out,
    output logic                          general_io_five_oe_n,
    output logic [SHARED_PINS-1:0]        shared_pin_is_lcd,
    output logic [5:0]                    lcd_segment_total,
    input  wire logic                     watchdog_sense_input,
    input  wire logic                     flash_lock_bit,
    input  wire logic                     emulator_enable_pin,
    output logic                          watchdog_enabled,
    output logic                          locked_reprogram_path,
    output logic                          internal_reset_n
);
    // shared pin index 0 is segment 26 / io 4 ... index 11 is segment 37
    function automatic logic [SHARED_PINS-1:0] lcd_map(
        input logic [SEG_COUNT_W-1:0] n);
        logic [SHARED_PINS-1:0] m;
        int                     k;
        m = '0;
        k = 0;
        if (n >= SEG_COUNT_W'(FIRST_MOVE)) begin // [RQ1]
            if (n <= SEG_COUNT_W'(KNEE_LOW))
                k = int'(n) - FIRST_MOVE + 1; // [RQ2]
            // counts between the knees hold the split steady
            else if (n <= SEG_COUNT_W'(KNEE_HIGH))
                k = KNEE_LOW - FIRST_MOVE + 1;
            else if (n <= SEG_COUNT_W'(MAX_SEG_COUNT))
                k = int'(n) - KNEE_HIGH + (KNEE_LOW - FIRST_MOVE + 1);
            else
                k = SHARED_PINS; // out-of-range count treated as 18 [RQ17]
        end
        for (int i = 0; i < SHARED_PINS; i++)
            m[i] = (SHARED_PINS - i) <= k;
        return m;
    endfunction

    function automatic logic [5:0] pop(input logic [SHARED_PINS-1:0] m);
        logic [5:0] c;
        c = 6'h0;
        for (int i = 0; i < SHARED_PINS; i++)
            c = c + 6'(m[i]);
        return c;
    endfunction

    carrier_if cif ();
    carrier_gen u_carrier (
        .clock   (clock),
        .reset_n (reset_n),
        .enable  (enable),
        .cif     (cif)
    );

    // internal power-on reset stretcher, no external circuit needed
    // saturating count: release happens once per reset, never wraps
    logic [POR_W-1:0] por_q, por_d;
    logic             por_n_q, por_n_d;
    always_comb begin
        por_d   = (por_q == POR_W'(POR_CYCLES)) ? por_q : por_q + 1'b1;
        por_n_d = (por_q == POR_W'(POR_CYCLES)); // [RQ14]
    end
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            por_q   <= '0;
            por_n_q <= 1'b0;
        end else if (enable) begin
            por_q   <= por_d;
            por_n_q <= por_n_d;
        end
    end

    // registered pin state
    logic [SHARED_PINS-1:0] lcd_q, lcd_d;
    logic [5:0]             segs_q, segs_d;
    logic                   io4_out_q, io4_out_d;
    logic                   io4_oe_n_q, io4_oe_n_d;
    logic                   io5_out_q, io5_out_d;
    logic                   io5_oe_n_q, io5_oe_n_d;
    logic [1:0]             gin_q, gin_d;
    logic                   ee_in_q, ee_in_d;
    logic                   tx_q, tx_d;
    logic                   tx_oe_n_q, tx_oe_n_d;
    logic                   rx_q, rx_d;
    logic                   wd_q, wd_d;
    logic                   lockp_q, lockp_d;
    logic                   tx_level;

    assign cif.run  = optical_carrier_enable && system_power_ok
                      && !brownout_mode; // [RQ9] [RQ10]
    assign cif.duty = carrier_duty_select;

    always_comb begin
        lcd_d  = lcd_map(segment_pin_count); // [RQ19]
        segs_d = 6'(DEDICATED_SEGS) + pop(lcd_d);

        // default: io four/five follow firmware gpio
        io4_out_d  = gpio_out[0];
        io4_oe_n_d = gpio_oe_n[0];
        io5_out_d  = gpio_out[1];
        io5_oe_n_d = gpio_oe_n[1];
        gin_d      = {general_io_five_in, general_io_four_in};
        ee_in_d    = 1'b1;

        unique case (eeprom_port_select)
            port_two_wire: begin // [RQ3]
                // open drain: drive only low, pull-up makes the high
                io4_out_d  = 1'b0;
                io4_oe_n_d = eeprom_clock_out;
                io5_out_d  = 1'b0;
                io5_oe_n_d = eeprom_data_out;
                ee_in_d    = general_io_five_in;
            end
            port_three_wire: begin // [RQ4]
                io4_out_d  = eeprom_clock_out;
                io4_oe_n_d = 1'b0;
                io5_out_d  = eeprom_data_out;
                io5_oe_n_d = !eeprom_data_drive; // [RQ5]
                ee_in_d    = general_io_five_in;
            end
            default: ; // gpio; reserved code also leaves pins as gpio
        endcase

        // a pad handed to the lcd is released by the io side, whatever
        // the eeprom routing asks for
        if (lcd_d[0]) begin
            io4_oe_n_d = 1'b1;
        end
        if (lcd_d[1]) begin
            io5_oe_n_d = 1'b1;
        end
        // chip select of three-wire parts stays on firmware gpio [RQ6]

        // invert applied last, so the carrier low phase flips with it
        tx_level  = cif.run ? (uart_tx_data && !cif.low) : uart_tx_data;
        tx_d      = tx_level ^ optical_transmit_invert; // [RQ8] [RQ12]
        tx_oe_n_d = optical_transmit_disable; // [RQ7]
        rx_d      = optical_receive_pin ^ optical_receive_invert; // [RQ8]
        // sense input is a comparator result: high means above 2.9 V
        wd_d      = !watchdog_sense_input; // [RQ13]
        // locked parts reprogram via emulator pin and watchdog reset
        lockp_d   = flash_lock_bit && emulator_enable_pin
                    && !watchdog_sense_input; // [RQ15] [RQ16]
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            lcd_q      <= '0;
            segs_q     <= 6'(DEDICATED_SEGS);
            io4_out_q  <= 1'b0;
            io4_oe_n_q <= 1'b1;
            io5_out_q  <= 1'b0;
            io5_oe_n_q <= 1'b1;
            gin_q      <= 2'h0;
            ee_in_q    <= 1'b1;
            tx_q       <= 1'b0;
            tx_oe_n_q  <= 1'b1;
            rx_q       <= 1'b0;
            wd_q       <= 1'b1;
            lockp_q    <= 1'b0;
        end else if (enable) begin
            lcd_q      <= lcd_d;
            segs_q     <= segs_d;
            io4_out_q  <= io4_out_d;
            io4_oe_n_q <= io4_oe_n_d;
            io5_out_q  <= io5_out_d;
            io5_oe_n_q <= io5_oe_n_d;
            gin_q      <= gin_d;
            ee_in_q    <= ee_in_d;
            tx_q       <= tx_d;
            tx_oe_n_q  <= tx_oe_n_d;
            rx_q       <= rx_d;
            wd_q       <= wd_d;
            lockp_q    <= lockp_d;
        end
    end

    assign shared_pin_is_lcd     = lcd_q;
    assign lcd_segment_total     = segs_q;
    assign general_io_four_out   = io4_out_q;
    assign general_io_four_oe_n  = io4_oe_n_q;
    assign general_io_five_out   = io5_out_q;
    assign general_io_five_oe_n  = io5_oe_n_q;
    assign gpio_in               = gin_q;
    assign eeprom_data_in        = ee_in_q;
    assign optical_transmit_pin  = tx_q;
    assign optical_transmit_oe_n = tx_oe_n_q;
    assign uart_rx_data          = rx_q;
    assign watchdog_enabled      = wd_q;
    assign locked_reprogram_path = lockp_q;
    assign internal_reset_n      = por_n_q;
endmodule // pin_function_and_optical_tx
`default_nettype wire

//--- verification/pin_function_asserts.sv
// Purpose: port-level checks for the pin function block
// Assumes: one clock, synchronous active-low reset
// Notes: first edge after reset or a frozen cycle is skipped
`default_nettype none
module pin_function_asserts
    import pin_function_pkg::*;
(
    input wire logic clock, reset_n, enable, uart_tx_data, uart_rx_data,
    input wire logic [SEG_COUNT_W-1:0] segment_pin_count,
    input wire pin_function_pkg::eeprom_port_t eeprom_port_select,
    input wire logic optical_transmit_disable, optical_transmit_invert,
    input wire logic optical_receive_invert, optical_carrier_enable,
    input wire logic brownout_mode, optical_receive_pin,
    input wire logic optical_transmit_pin, optical_transmit_oe_n,
    input wire logic eeprom_clock_out, eeprom_data_drive,
    input wire logic general_io_four_oe_n, general_io_five_oe_n,
    input wire logic [SHARED_PINS-1:0] shared_pin_is_lcd,
    input wire logic [5:0] lcd_segment_total,
    input wire logic watchdog_sense_input, watchdog_enabled, internal_reset_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       live_q;
    logic [4:0] age_q;
    // outputs lag inputs by one edge, so the edge after reset is not judged
    always_ff @(posedge clock) begin
        live_q <= reset_n && enable;
        if (!reset_n) age_q <= 5'h0;
        else if (enable && age_q != 5'h1f) age_q <= age_q + 5'h1;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n || !live_q || !enable);
    sequence plain_tx_s;
        (!optical_transmit_disable
            && (!optical_carrier_enable || brownout_mode))[*3];
    endsequence
    sequence three_wire_s;
        $past(eeprom_port_select) == port_three_wire
            && $past(segment_pin_count) < 5'h11;
    endsequence
    chk_rx_polarity: assert property (
        uart_rx_data == $past(optical_receive_pin ^ optical_receive_invert))
        else $error("receive data polarity wrong");
    chk_tx_release: assert property (
        optical_transmit_oe_n == $past(optical_transmit_disable))
        else $error("transmit enable wrong");
    chk_tx_unmodulated: assert property (
        plain_tx_s |=> optical_transmit_pin
            == $past(uart_tx_data ^ optical_transmit_invert))
        else $error("transmit carries a carrier when it should not");
    chk_seg_none: assert property (
        $past(segment_pin_count) < 5'h5 |-> shared_pin_is_lcd == 12'h0
            && lcd_segment_total == 6'h13)
        else $error("low segment count moved shared pins");
    chk_seg_full: assert property (
        $past(segment_pin_count) == 5'h12 |-> &shared_pin_is_lcd
            && lcd_segment_total == 6'h1f)
        else $error("full segment count wrong");
    chk_two_wire: assert property (
        $past(eeprom_port_select) == port_two_wire
            && $past(segment_pin_count) < 5'h12
            |-> general_io_four_oe_n == $past(eeprom_clock_out))
        else $error("two-wire clock not open drain");
    chk_three_wire: assert property (
        three_wire_s |-> !general_io_four_oe_n
            && general_io_five_oe_n == !$past(eeprom_data_drive))
        else $error("three-wire pin direction wrong");
    chk_watchdog_sense: assert property (
        watchdog_enabled == !$past(watchdog_sense_input))
        else $error("watchdog enable wrong");
    chk_por_stretch: assert property (
        (age_q < 5'h10 |-> !internal_reset_n)
            and (age_q > 5'h13 |-> internal_reset_n))
        else $error("internal reset stretch wrong");
endmodule // pin_function_asserts
bind pin_function_and_optical_tx pin_function_asserts chk (.*);
`default_nettype wire

//--- verification/far_side_model.sv
// Purpose: memory data line, line pull-ups and optical receiver
// Assumes: pull-ups on both shared lines
// Notes: a released line reads the pull-up level unless the memory drives io5, never the last value
`default_nettype none
module far_side_model (
    input  wire logic io4_out, io4_oe_n, io5_out, io5_oe_n,
    input  wire logic far_drive, far_bit, rx_level,
    output logic      io4_level, io5_level, rx_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    assign io4_level = io4_oe_n ? 1'b1 : io4_out;
    // memory drives only when told and the device has let go
    assign io5_level = !io5_oe_n ? io5_out : (far_drive ? far_bit : 1'b1);
    // chip select sits on a spare firmware pin, not here
    assign rx_pin = rx_level;
endmodule // far_side_model
`default_nettype wire

//--- verification/pin_function_and_optical_tx_bench.sv
// Purpose: directed tests of pin split, memory port and optical port
// Assumes: enable held high except in the freeze test
// Notes: carrier low time counted over one full period
`default_nettype none
module pin_function_and_optical_tx_bench import pin_function_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, reset_n = 1'b0, enable = 1'b1;
    logic [4:0] segment_pin_count = 5'h0;
    eeprom_port_t eeprom_port_select = port_gpio;
    duty_t carrier_duty_select = duty_half;
    logic optical_transmit_disable = 1'b1, optical_transmit_invert = 1'b0,
        optical_receive_invert = 1'b0, optical_carrier_enable = 1'b0,
        system_power_ok = 1'b1, brownout_mode = 1'b0, uart_tx_data = 1'b1,
        eeprom_clock_out = 1'b0, eeprom_data_out = 1'b0,
        eeprom_data_drive = 1'b0, watchdog_sense_input = 1'b0,
        flash_lock_bit = 1'b0, emulator_enable_pin = 1'b0;
    logic [1:0] gpio_out = 2'h0, gpio_oe_n = 2'h3, gpio_in;
    logic far_drive = 1'b0, far_bit = 1'b0, rx_level = 1'b1;
    logic uart_rx_data, optical_transmit_pin, optical_transmit_oe_n,
        eeprom_data_in, general_io_four_out, general_io_four_oe_n,
        general_io_five_out, general_io_five_oe_n, watchdog_enabled,
        locked_reprogram_path, internal_reset_n, general_io_four_in,
        general_io_five_in, optical_receive_pin;
    logic [11:0] shared_pin_is_lcd;
    logic [5:0] lcd_segment_total;
    int err_count = 0, compares = 0, cycles = 0, k, lows;
    pin_function_and_optical_tx DUT (.*);
    far_side_model far (.io4_out(general_io_four_out),
        .io4_oe_n(general_io_four_oe_n), .io5_out(general_io_five_out),
        .io5_oe_n(general_io_five_oe_n), .far_drive, .far_bit, .rx_level,
        .io4_level(general_io_four_in), .io5_level(general_io_five_in),
        .rx_pin(optical_receive_pin));
    initial begin
        forever #5 clock = ~clock;
    end
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tdone(input string name);
        $display("test %s done", name);
    endtask
    task automatic final_report;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            $display("BAD %0t run did not finish", $time);
            final_report();
        end
    end
    initial begin
        settle(2);
        chk({optical_transmit_oe_n, general_io_four_oe_n,
            general_io_five_oe_n, watchdog_enabled, internal_reset_n},
            5'h1e);
        chk(lcd_segment_total, 6'h13);
        @(posedge clock) reset_n <= 1'b1;
        settle(10);
        chk(internal_reset_n, 1'b0);
        settle(12);
        chk(internal_reset_n, 1'b1);
        tdone("reset");
        // firmware keeps the count within 0..18
        for (int n = 0; n <= 18; n++) begin
            @(posedge clock) segment_pin_count <= 5'(n);
            settle(1);
            k = n < 5 ? 0 : n <= 8 ? n - 4 : n <= 10 ? 4 : n - 6;
            chk(shared_pin_is_lcd, 12'hfff << (12 - k));
            chk(lcd_segment_total, 12'(19 + k));
        end
        tdone("segments");
        @(posedge clock) begin
            segment_pin_count <= 5'h0;
            gpio_oe_n <= 2'h1;
            eeprom_clock_out <= 1'b1;
        end
        for (int s = 0; s < 4; s += 3) begin
            @(posedge clock) eeprom_port_select <= eeprom_port_t'(s);
            settle(2);
            chk({general_io_four_out, general_io_four_oe_n, general_io_five_out,
                general_io_five_oe_n, gpio_in, eeprom_data_in}, 7'h23);
        end
        @(posedge clock) eeprom_port_select <= port_two_wire;
        settle(2);
        chk({general_io_four_out, general_io_four_oe_n, general_io_five_out,
            general_io_five_oe_n, eeprom_data_in}, 5'h08);
        @(posedge clock) begin
            eeprom_port_select <= port_three_wire;
            eeprom_data_out <= 1'b1;
            far_drive <= 1'b1;
        end
        settle(2);
        chk({general_io_four_out, general_io_four_oe_n, general_io_five_oe_n,
            eeprom_data_in}, 4'ha);
        @(posedge clock) begin
            eeprom_data_drive <= 1'b1;
            far_drive <= 1'b0;
        end
        settle(2);
        chk({general_io_five_out, general_io_five_oe_n, eeprom_data_in},
            3'h5);
        @(posedge clock) segment_pin_count <= 5'h12;
        settle(1);
        chk({general_io_four_oe_n, general_io_five_oe_n}, 2'h3);
        tdone("eeprom");
        for (int i = 0; i < 4; i++) begin
            @(posedge clock) begin
                optical_transmit_disable <= (i == 0);
                {optical_transmit_invert, optical_receive_invert} <= 2'(i);
            end
            settle(1);
            chk({optical_transmit_oe_n, optical_transmit_pin, uart_rx_data},
                {i == 0, ~i[1], ~i[0]});
        end
        tdone("optical");
        @(posedge clock) begin
            optical_carrier_enable <= 1'b1;
            optical_transmit_invert <= 1'b0;
        end
        for (int d = 0; d < 6; d++) begin
            @(posedge clock) begin
                carrier_duty_select <= duty_t'(d % 4);
                brownout_mode <= (d == 4);
                system_power_ok <= (d != 5);
            end
            settle(CARRIER_CYCLES);
            lows = 0;
            repeat (CARRIER_CYCLES) begin
                settle(1);
                lows += int'(optical_transmit_pin === 1'b0);
            end
            chk(12'(lows), 12'(d > 3 ? 0 : CARRIER_CYCLES >> (d + 1)));
        end
        tdone("carrier");
        for (int i = 0; i < 8; i++) begin
            @(posedge clock) {flash_lock_bit, emulator_enable_pin,
                watchdog_sense_input} <= 3'(i);
            settle(2);
            chk({watchdog_enabled, locked_reprogram_path},
                {~i[0], i[2] & i[1] & ~i[0]});
        end
        tdone("watchdog");
        // clock enable low must freeze the split although the count moves
        @(posedge clock) begin
            enable <= 1'b0;
            segment_pin_count <= 5'h0;
        end
        settle(3);
        chk(shared_pin_is_lcd, 12'hfff);
        chk(lcd_segment_total, 12'h01f);
        @(posedge clock) enable <= 1'b1;
        settle(1);
        chk(shared_pin_is_lcd, 12'h000);
        chk(lcd_segment_total, 12'h013);
        tdone("freeze");
        final_report();
    end
endmodule // pin_function_and_optical_tx_bench
`default_nettype wire
